// file: core/dsr_readback.sv
// identity and status read-back over the serial link and the parallel bus
`timescale 1ns/1ps

// Notes on behaviour
// - identity command returns a 24-bit word
// - one dummy clock, then identity MSB first
// - parallel identity: command, dummy, three bytes
// - top byte fixed, rest from OTP
// - status command returns 32 bits, any mode
// - one dummy clock, then four status bytes
// - bit 31 is booster selected and ready
// - bits 30..26 mirror memory access settings
// - bits 25..23 read zero
// - bits 22..20 carry pixel format
// - bits 19..16 idle, partial, awake, normal
// - bit 15 shows vertical scrolling
// - bits 13..9 display flags
// - bit 14 and bits 8..0 zero
// - parallel status: command, dummy, four bytes
module dsr_readback #(
    parameter logic [7:0] MFR_ID = 8'h5a // arbitrary manufacturer value
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   serial_mode_i,
    input  wire dsr_pkg::dsr_settings_s settings_i,
    input  wire dsr_pkg::dsr_otp_s      otp_i,
    input  wire logic                   link_clk_i,
    input  wire logic                   serial_chip_enable_n_i,
    input  wire logic                   sdin_i,
    output logic                        sdout_o,
    output logic                        sdout_oe_n_o,
    input  wire logic                   par_dc_i,
    input  wire logic                   par_wr_n_i,
    input  wire logic                   par_rd_n_i,
    input  wire logic [7:0]             par_data_i,
    output logic [7:0]                  par_data_o,
    output logic                        par_data_oe_n_o
);

    logic rst_q1_r, rst_n_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_q1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_q1_r <= 1'b1;
            rst_n_r  <= rst_q1_r;
        end
    end

    // word assembly
    wire dsr_pkg::dsr_settings_s s = settings_i;
    wire logic [31:0] st_word = {
        s.booster_on_sel & s.supply_ready,
        s.row_flip, s.col_flip, s.col_first, s.line_order,
        s.color_order,
        3'h0,
        s.pixel_format,
        s.idle, s.partial, s.awake, s.normal,
        s.scrolling,
        1'b0,
        s.inverted, s.all_lit, s.all_dark, s.panel_on,
        s.tear_signal_on,
        9'h000
    };
    wire logic [23:0] id_word = {MFR_ID, otp_i.colour, otp_i.version,
                                 otp_i.module_code};

    // parallel bus pins: two flops, then a third on the write and read strobes for edge detection
    logic [2:0] wr_q_r, rd_q_r;
    logic [1:0] dc_q_r, mode_q_r;
    logic [7:0] dat_q1_r, dat_q2_r;
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wr_q_r   <= 3'h7;
            rd_q_r   <= 3'h7;
            dc_q_r   <= 2'h0;
            mode_q_r <= 2'h0;
            dat_q1_r <= dsr_pkg::BYTE_RST;
            dat_q2_r <= dsr_pkg::BYTE_RST;
        end else begin
            wr_q_r   <= {wr_q_r[1:0], par_wr_n_i};
            rd_q_r   <= {rd_q_r[1:0], par_rd_n_i};
            dc_q_r   <= {dc_q_r[0], par_dc_i};
            mode_q_r <= {mode_q_r[0], serial_mode_i};
            dat_q1_r <= par_data_i;
            dat_q2_r <= dat_q1_r;
        end
    end

    wire logic par_on   = ~mode_q_r[1];
    wire logic wr_rise  = par_on & wr_q_r[1] & ~wr_q_r[2];
    wire logic rd_fall  = par_on & ~rd_q_r[1] & rd_q_r[2];
    wire logic rd_rise  = par_on & rd_q_r[1] & ~rd_q_r[2];
    wire logic cmd_wr   = wr_rise & ~dc_q_r[1];
    wire logic is_id    = dat_q2_r == dsr_pkg::CMD_READ_IDENTITY;
    wire logic is_st    = dat_q2_r == dsr_pkg::CMD_READ_STATUS;

    logic [2:0] par_left_r, par_left_nxt;
    logic       par_st_r;
    wire logic  par_active = (par_left_r != dsr_pkg::PAR_LEFT_RST) & dc_q_r[1];
    wire logic [31:0] par_word = par_st_r ? st_word : {8'h00, id_word};
    wire logic [7:0]  par_byte =
        (par_left_r == 3'h4) ? par_word[31:24] :
        (par_left_r == 3'h3) ? par_word[23:16] :
        (par_left_r == 3'h2) ? par_word[15:8]  :
        (par_left_r == 3'h1) ? par_word[7:0]   : dsr_pkg::BYTE_RST;

    // any command byte restarts decoding, so an unfinished read is dropped
    assign par_left_nxt =
        cmd_wr ? (is_id ? dsr_pkg::PAR_ID_READS :
                  is_st ? dsr_pkg::PAR_ST_READS :
                  dsr_pkg::PAR_LEFT_RST) :
        (rd_rise & par_active) ? par_left_r - 3'h1 : par_left_r;

    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            par_left_r      <= dsr_pkg::PAR_LEFT_RST;
            par_st_r        <= 1'b0;
            par_data_o      <= dsr_pkg::BYTE_RST;
            par_data_oe_n_o <= 1'b1;
        end else begin
            par_left_r <= par_left_nxt;
            if (cmd_wr) begin
                par_st_r <= is_st;
            end
            if (rd_fall & par_active) begin
                par_data_o      <= par_byte;
                par_data_oe_n_o <= 1'b0;
            end else if (rd_rise | cmd_wr) begin
                par_data_oe_n_o <= 1'b1;
            end
        end
    end

    // snapshot of both words handed to the link domain by toggle handshake
    logic [55:0] snap_r;
    logic        req_r;
    logic [1:0]  ack_q_r;
    logic [2:0]  req_q_r;
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            snap_r  <= 56'h0;
            req_r   <= 1'b0;
            ack_q_r <= 2'h0;
        end else begin
            ack_q_r <= {ack_q_r[0], req_q_r[2]};
            if (ack_q_r[1] == req_r) begin
                snap_r <= {st_word, id_word};
                req_r  <= ~req_r;
            end
        end
    end

    logic [55:0] link_snap_r;
    always_ff @(posedge link_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            req_q_r     <= 3'h0;
            link_snap_r <= 56'h0;
        end else begin
            req_q_r <= {req_q_r[1:0], req_r};
            if (req_q_r[1] != req_q_r[2]) begin
                link_snap_r <= snap_r;
            end
        end
    end

    // serial link: chip enable high ends any frame at once
    wire logic link_rst_n = rst_n_r & ~serial_chip_enable_n_i;

    dsr_pkg::dsr_link_e link_st_r, link_st_nxt;
    logic [5:0]  cnt_r, cnt_nxt;
    logic [8:0]  cmd_r;
    logic        ser_st_r;
    logic [31:0] shift_r;
    logic        sdout_r, oe_n_r;

    wire logic [7:0] ser_byte  = {cmd_r[6:0], sdin_i};
    wire logic       ser_done  = cnt_r == dsr_pkg::SER_CMD_LAST;
    wire logic       ser_cmd   = ser_done & ~cmd_r[7];
    wire logic       ser_id    = ser_cmd & (ser_byte == dsr_pkg::CMD_READ_IDENTITY);
    wire logic       ser_stat  = ser_cmd & (ser_byte == dsr_pkg::CMD_READ_STATUS);
    wire logic [5:0] ser_bits  = ser_st_r ? dsr_pkg::SER_ST_BITS : dsr_pkg::SER_ID_BITS;
    wire logic [31:0] ser_load = ser_st_r ? link_snap_r[55:24]
                                          : {link_snap_r[23:0], 8'h00};
    wire logic       ser_last  = cnt_r == ser_bits;

    always_comb begin
        link_st_nxt = link_st_r;
        cnt_nxt     = cnt_r;
        unique case (link_st_r)
            dsr_pkg::LINK_CMD: begin
                cnt_nxt = ser_done ? dsr_pkg::SER_CNT_RST : cnt_r + 6'h01;
                if (ser_id | ser_stat) begin
                    link_st_nxt = dsr_pkg::LINK_DUMMY;
                end
            end
            dsr_pkg::LINK_DUMMY: begin
                cnt_nxt     = 6'h01;
                link_st_nxt = dsr_pkg::LINK_SHIFT;
            end
            dsr_pkg::LINK_SHIFT: begin
                cnt_nxt = ser_last ? dsr_pkg::SER_CNT_RST : cnt_r + 6'h01;
                if (ser_last) begin
                    link_st_nxt = dsr_pkg::LINK_CMD;
                end
            end
            default: begin
                link_st_nxt = dsr_pkg::LINK_CMD;
                cnt_nxt     = dsr_pkg::SER_CNT_RST;
            end
        endcase
    end

    always_ff @(posedge link_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link_st_r <= dsr_pkg::LINK_CMD;
            cnt_r     <= dsr_pkg::SER_CNT_RST;
            cmd_r     <= dsr_pkg::CMD_SHIFT_RST;
            ser_st_r  <= 1'b0;
            shift_r   <= dsr_pkg::WORD_RST;
            sdout_r   <= 1'b0;
            oe_n_r    <= 1'b1;
        end else begin
            link_st_r <= link_st_nxt;
            cnt_r     <= cnt_nxt;
            cmd_r     <= {cmd_r[7:0], sdin_i};
            if (ser_id | ser_stat) begin
                ser_st_r <= ser_stat;
            end
            if (link_st_r == dsr_pkg::LINK_DUMMY) begin
                shift_r <= ser_load;
                sdout_r <= ser_load[31];
                oe_n_r  <= 1'b0;
            end else if (link_st_r == dsr_pkg::LINK_SHIFT) begin
                shift_r <= {shift_r[30:0], 1'b0};
                sdout_r <= shift_r[30];
                oe_n_r  <= ser_last;
            end
        end
    end

    assign sdout_o      = sdout_r;
    assign sdout_oe_n_o = oe_n_r;

    // checks on the serial link
    property p_ser_id_decode;
        @(posedge link_clk_i) disable iff (!link_rst_n)
        (link_st_r == dsr_pkg::LINK_CMD) && ser_id |=>
            (link_st_r == dsr_pkg::LINK_DUMMY) && !ser_st_r && oe_n_r;
    endproperty
    a_ser_id_decode: assert property (p_ser_id_decode)
        else $error("identity command not decoded");

    property p_ser_st_decode;
        @(posedge link_clk_i) disable iff (!link_rst_n)
        (link_st_r == dsr_pkg::LINK_CMD) && ser_stat |=>
            (link_st_r == dsr_pkg::LINK_DUMMY) && ser_st_r && oe_n_r;
    endproperty
    a_ser_st_decode: assert property (p_ser_st_decode)
        else $error("status command not decoded");

    property p_ser_id_len;
        @(posedge link_clk_i) disable iff (!link_rst_n)
        (link_st_r == dsr_pkg::LINK_DUMMY) && !ser_st_r |=>
            !oe_n_r ##23 !oe_n_r ##1 oe_n_r;
    endproperty
    a_ser_id_len: assert property (p_ser_id_len)
        else $error("identity read not 24 bits after dummy");

    property p_ser_st_len;
        @(posedge link_clk_i) disable iff (!link_rst_n)
        (link_st_r == dsr_pkg::LINK_DUMMY) && ser_st_r |=>
            !oe_n_r ##31 !oe_n_r ##1 oe_n_r;
    endproperty
    a_ser_st_len: assert property (p_ser_st_len)
        else $error("status read not 32 bits after dummy");

    property p_ser_other_cmd;
        @(posedge link_clk_i) disable iff (!link_rst_n)
        (link_st_r == dsr_pkg::LINK_CMD) && ser_done && !ser_id && !ser_stat |=>
            (link_st_r == dsr_pkg::LINK_CMD) && (cnt_r == dsr_pkg::SER_CNT_RST);
    endproperty
    a_ser_other_cmd: assert property (p_ser_other_cmd)
        else $error("other command left command state");

    // checks on the status word and the parallel bus
    property p_booster_bit;
        @(posedge clk_i) disable iff (!rst_n_r)
        st_word[31] == (settings_i.booster_on_sel && settings_i.supply_ready);
    endproperty
    a_booster_bit: assert property (p_booster_bit)
        else $error("booster status bit wrong");

    property p_zero_bits;
        @(posedge clk_i) disable iff (!rst_n_r)
        (st_word[25:23] == 3'h0) && !st_word[14] && (st_word[8:0] == 9'h000);
    endproperty
    a_zero_bits: assert property (p_zero_bits)
        else $error("reserved status bits not zero");

    property p_par_id_start;
        @(posedge clk_i) disable iff (!rst_n_r)
        cmd_wr && is_id |=> par_left_r == dsr_pkg::PAR_ID_READS;
    endproperty
    a_par_id_start: assert property (p_par_id_start)
        else $error("parallel identity read not armed");

    property p_par_dummy;
        @(posedge clk_i) disable iff (!rst_n_r)
        rd_fall && par_active && par_st_r && (par_left_r == dsr_pkg::PAR_ST_READS)
            |=> (par_data_o == dsr_pkg::BYTE_RST) && !par_data_oe_n_o;
    endproperty
    a_par_dummy: assert property (p_par_dummy)
        else $error("parallel dummy byte not zero");

    property p_par_st_top;
        @(posedge clk_i) disable iff (!rst_n_r)
        rd_fall && par_active && par_st_r && (par_left_r == 3'h4)
            |=> par_data_o == $past(st_word[31:24]);
    endproperty
    a_par_st_top: assert property (p_par_st_top)
        else $error("first status byte is not bits 31 to 24");

    property p_par_st_start;
        @(posedge clk_i) disable iff (!rst_n_r)
        cmd_wr && is_st |=> par_left_r == dsr_pkg::PAR_ST_READS;
    endproperty
    a_par_st_start: assert property (p_par_st_start)
        else $error("parallel status read not armed");

    property p_par_other_cmd;
        @(posedge clk_i) disable iff (!rst_n_r)
        cmd_wr && !is_id && !is_st |=> par_left_r == dsr_pkg::PAR_LEFT_RST;
    endproperty
    a_par_other_cmd: assert property (p_par_other_cmd)
        else $error("other parallel command left a read armed");

    property p_par_id_top;
        @(posedge clk_i) disable iff (!rst_n_r)
        rd_fall && par_active && !par_st_r && (par_left_r == 3'h3) |=> par_data_o == MFR_ID;
    endproperty
    a_par_id_top: assert property (p_par_id_top)
        else $error("first identity byte is not the maker value");

endmodule : dsr_readback

// file: common/dsr_pkg.sv
// shared constants and types of the identity/status read-back block
package dsr_pkg;

    localparam logic [7:0] CMD_READ_IDENTITY = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS   = 8'h09;

    // serial frame: one select bit then eight data bits, so nine clocks
    localparam logic [5:0] SER_CMD_LAST  = 6'h08;
    localparam logic [5:0] SER_ID_BITS   = 6'h18;
    localparam logic [5:0] SER_ST_BITS   = 6'h20;
    localparam logic [5:0] SER_CNT_RST   = 6'h00;

    // parallel read count: one dummy byte plus the word bytes
    localparam logic [2:0] PAR_ID_READS  = 3'h4;
    localparam logic [2:0] PAR_ST_READS  = 3'h5;
    localparam logic [2:0] PAR_LEFT_RST  = 3'h0;

    localparam logic [7:0]  BYTE_RST     = 8'h00;
    localparam logic [31:0] WORD_RST     = 32'h0000_0000;
    localparam logic [8:0]  CMD_SHIFT_RST = 9'h000;

    typedef enum logic [1:0] {
        LINK_CMD   = 2'b00,
        LINK_DUMMY = 2'b01,
        LINK_SHIFT = 2'b10
    } dsr_link_e;

    typedef struct packed {
        logic       booster_on_sel;
        logic       supply_ready;
        logic       row_flip;
        logic       col_flip;
        logic       col_first;
        logic       line_order;
        logic       color_order;
        logic [2:0] pixel_format;
        logic       idle;
        logic       partial;
        logic       awake;
        logic       normal;
        logic       scrolling;
        logic       inverted;
        logic       all_lit;
        logic       all_dark;
        logic       panel_on;
        logic       tear_signal_on;
    } dsr_settings_s;

    typedef struct packed {
        logic       colour;
        logic [6:0] version;
        logic [7:0] module_code;
    } dsr_otp_s;

endpackage : dsr_pkg

// file: verif/dsr_host_model.sv
// host processor model driving the serial link and the parallel bus
`timescale 1ns/1ps
module dsr_host_model (
    input  wire logic       clk_i,
    input  wire logic       sdout_i,
    input  wire logic       sdout_oe_n_i,
    input  wire logic [7:0] pdata_i,
    input  wire logic       poe_n_i,
    output logic            link_clk_o,
    output logic            sce_n_o,
    output logic            sdin_o,
    output logic            dc_o,
    output logic            wr_n_o,
    output logic            rd_n_o,
    output logic [7:0]      pdata_o
);
    initial begin
        link_clk_o = 1'b0;
        sce_n_o = 1'b1;
        sdin_o = 1'b0;
        dc_o = 1'b1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        pdata_o = 8'h00;
    end
    // one 12 ns link period; the link clock rests low between frames
    task automatic tick();
        #6 link_clk_o = 1'b1;
        #6 link_clk_o = 1'b0;
    endtask : tick
    task automatic ser_cmd(input logic sel, input logic [7:0] b);
        logic [8:0] f;
        f = {sel, b};
        // clock with chip enable high first, so a fresh word snapshot reaches the link side
        if (sce_n_o === 1'b1) repeat (32) tick();
        sce_n_o = 1'b0;
        for (int i = 8; i >= 0; i--) begin
            sdin_o = f[i];
            tick();
        end
        sdin_o = ~sdin_o;
    endtask : ser_cmd
    // dummy clock, then n bits taken while the link clock is low
    task automatic ser_read(input int n, output logic [31:0] w, output int bad);
        w = 32'h0000_0000;
        bad = 0;
        tick();
        for (int i = 0; i < n; i++) begin
            w = {w[30:0], sdout_i};
            if (sdout_oe_n_i !== 1'b0) bad++;
            tick();
        end
    endtask : ser_read
    // rising chip enable closes a frame, also a short one
    task automatic ser_end();
        #6 sce_n_o = 1'b1;
        #20;
    endtask : ser_end
    task automatic par_wr(input logic [7:0] b);
        @(posedge clk_i);
        #1;
        dc_o = 1'b0;
        pdata_o = b;
        wr_n_o = 1'b0;
        repeat (6) @(posedge clk_i);
        #1 wr_n_o = 1'b1;
        repeat (6) @(posedge clk_i);
        #1 pdata_o = ~b;
    endtask : par_wr
    task automatic par_rd(output logic [7:0] d, output logic oe_n);
        @(posedge clk_i);
        #1;
        dc_o = 1'b1;
        rd_n_o = 1'b0;
        repeat (6) @(posedge clk_i);
        d = pdata_i;
        oe_n = poe_n_i;
        #1 rd_n_o = 1'b1;
        repeat (6) @(posedge clk_i);
    endtask : par_rd
endmodule : dsr_host_model

// file: verif/tb_top.sv
// self-checking bench for the identity and status read-back block
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] MFR = 8'hc3; // arbitrary maker value
    logic                   clk_i = 1'b0;
    logic                   rst_n_i = 1'b0;
    logic                   serial_mode_i = 1'b1;
    dsr_pkg::dsr_settings_s settings_i = '0;
    dsr_pkg::dsr_otp_s      otp_i = '0;
    logic                   lclk, sce_n, sdin, sdout, soe_n, dc, wr_n, rd_n, poe_n;
    logic [7:0]             pdi, pdo;
    logic [21:0]            pats [5] = '{22'h3fffff, 22'h2aaaaa, 22'h155555, 22'h200000,
                                         22'h30f0f0};
    int                     num_errors = 0;
    int                     total_checks = 0;

    always #20 clk_i = ~clk_i;

    dsr_readback #(.MFR_ID(MFR)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .serial_mode_i(serial_mode_i), .settings_i(settings_i), .otp_i(otp_i),
        .link_clk_i(lclk), .serial_chip_enable_n_i(sce_n), .sdin_i(sdin), .sdout_o(sdout),
        .sdout_oe_n_o(soe_n), .par_dc_i(dc), .par_wr_n_i(wr_n), .par_rd_n_i(rd_n),
        .par_data_i(pdi), .par_data_o(pdo), .par_data_oe_n_o(poe_n));

    dsr_host_model host (.clk_i(clk_i), .sdout_i(sdout), .sdout_oe_n_i(soe_n),
        .pdata_i(pdo), .poe_n_i(poe_n), .link_clk_o(lclk), .sce_n_o(sce_n), .sdin_o(sdin),
        .dc_o(dc), .wr_n_o(wr_n), .rd_n_o(rd_n), .pdata_o(pdi));

    function automatic logic [31:0] exp_st(input dsr_pkg::dsr_settings_s s);
        return {s.booster_on_sel & s.supply_ready, s.row_flip, s.col_flip, s.col_first,
                s.line_order, s.color_order, 3'h0, s.pixel_format, s.idle, s.partial,
                s.awake, s.normal, s.scrolling, 1'h0, s.inverted, s.all_lit, s.all_dark,
                s.panel_on, s.tear_signal_on, 9'h000};
    endfunction : exp_st

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask : chk

    task automatic settle();
        repeat (10) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic ser_word(input logic [7:0] c, input int n, input logic [31:0] e);
        logic [31:0] w;
        int          bad;
        host.ser_cmd(1'b0, c);
        host.ser_read(n, w, bad);
        chk("serial word", e, w);
        chk("serial drive", 0, bad);
        chk("serial release", 1, soe_n);
        host.ser_end();
    endtask : ser_word

    task automatic t_serial();
        logic [31:0] w;
        int          bad;
        otp_i = dsr_pkg::dsr_otp_s'(16'h8a3c);
        settle();
        ser_word(dsr_pkg::CMD_READ_IDENTITY, 24, {8'h00, MFR, otp_i});
        otp_i = dsr_pkg::dsr_otp_s'(16'h35c3);
        for (int i = 0; i < 5; i++) begin
            settings_i = dsr_pkg::dsr_settings_s'(pats[i]);
            settle();
            ser_word(dsr_pkg::CMD_READ_STATUS, 32, exp_st(settings_i));
        end
        host.ser_cmd(1'b0, dsr_pkg::CMD_READ_STATUS);
        host.ser_read(10, w, bad);
        host.ser_end();
        chk("abort release", 1, soe_n);
        ser_word(dsr_pkg::CMD_READ_IDENTITY, 24, {8'h00, MFR, otp_i});
        host.ser_cmd(1'b1, dsr_pkg::CMD_READ_STATUS);
        host.ser_read(8, w, bad);
        chk("data frame ignored", 8, bad);
        host.ser_end();
        host.ser_cmd(1'b0, 8'h05);
        host.ser_read(8, w, bad);
        chk("other code ignored", 8, bad);
        host.ser_end();
        $display("serial test done");
    endtask : t_serial

    task automatic par_seq(input logic [7:0] c, input int n, input logic [31:0] e);
        logic [7:0] d;
        logic       oe;
        host.par_wr(c);
        host.par_rd(d, oe);
        chk("dummy byte", 8'h00, d);
        chk("dummy drive", 0, oe);
        for (int k = 0; k < n; k++) begin
            host.par_rd(d, oe);
            chk("parallel byte", e[8*(n-1-k) +: 8], d);
            chk("parallel drive", 0, oe);
        end
    endtask : par_seq

    task automatic t_parallel();
        logic [7:0] d;
        logic       oe;
        serial_mode_i = 1'b0;
        settings_i = dsr_pkg::dsr_settings_s'(pats[1]);
        settle();
        host.par_rd(d, oe);
        chk("unarmed read", 1, oe);
        par_seq(dsr_pkg::CMD_READ_IDENTITY, 3, {8'h00, MFR, otp_i});
        par_seq(dsr_pkg::CMD_READ_STATUS, 4, exp_st(settings_i));
        host.par_wr(dsr_pkg::CMD_READ_STATUS);
        host.par_rd(d, oe);
        par_seq(dsr_pkg::CMD_READ_IDENTITY, 3, {8'h00, MFR, otp_i});
        $display("parallel test done");
    endtask : t_parallel

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    initial begin
        #2000000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        // identity settle wait after reset, shortened for the run
        repeat (20) @(posedge clk_i);
        t_serial();
        t_parallel();
        report_and_stop();
    end
endmodule : tb_top
